// ==== shared/swk_mode_pkg.sv ====
package swk_mode_pkg;
    // =========================================
    // Channel mode field encodings
    localparam logic [2:0] MODE_OFF0 = 3'h0;
    localparam logic [2:0] MODE_WAKE = 3'h1;
    localparam logic [2:0] MODE_RXONLY = 3'h2;
    localparam logic [2:0] MODE_NORMAL = 3'h3;
    localparam logic [2:0] MODE_OFF1 = 3'h4;
    localparam logic [2:0] MODE_SWK = 3'h5;
    localparam logic [2:0] MODE_RXONLY_SWK = 3'h6;
    localparam logic [2:0] MODE_NORMAL_SWK = 3'h7;
    localparam int WAKE_SEL_POS = 2;
    // =========================================
    // Reset values
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic ERR_RESET = 1'b0;
    localparam logic CFG_RESET = 1'b0;
    // =========================================
    // Controller register offsets (word index)
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h1;
    // =========================================
    // Device states and command codes
    typedef enum logic [2:0] {
        DEV_NORMAL, DEV_STOP, DEV_SLEEP, DEV_RESTART, DEV_FAILSAFE
    } dev_state_t;
    localparam logic [2:0] CMD_NONE = 3'h0;
    localparam logic [2:0] CMD_WRITE_MODE = 3'h1;
    localparam logic [2:0] CMD_STOP = 3'h2;
    localparam logic [2:0] CMD_SLEEP = 3'h3;
    localparam logic [2:0] CMD_NORMAL = 3'h4;
    localparam logic [2:0] CMD_RESTART = 3'h5;
    localparam logic [2:0] CMD_FAILSAFE = 3'h6;
    localparam logic [2:0] CMD_CLR_ERR = 3'h7;

    // Effective channel operation decoded from field
    typedef enum logic [2:0] {
        OP_OFF, OP_WAKE, OP_RXONLY, OP_NORMAL
    } chan_op_t;

    // True when a mode carries selective wake
    function automatic logic is_swk_mode(input logic [2:0] m);
        return m[WAKE_SEL_POS] && (m[1:0] != 2'h0);
    endfunction : is_swk_mode
endpackage : swk_mode_pkg

// ==== shared/swk_mode_if.sv ====
`timescale 1ns/1ps
interface swk_mode_if;
    logic cmd_valid;
    logic [2:0] cmd_code;
    logic [2:0] cmd_mode;
    logic cfg_valid_set;
    logic [2:0] mode_readback;
    logic selwake_error_flag;
    logic selwake_armed_flag;
    logic bus_silence_flag;
    logic selwake_config_valid;
    logic wake_irq;
    logic [2:0] dev_state;
    modport device (
        input cmd_valid, cmd_code, cmd_mode, cfg_valid_set,
        output mode_readback, selwake_error_flag, selwake_armed_flag,
        output bus_silence_flag, selwake_config_valid, wake_irq, dev_state
    );
    modport host (
        output cmd_valid, cmd_code, cmd_mode, cfg_valid_set,
        input mode_readback, selwake_error_flag, selwake_armed_flag,
        input bus_silence_flag, selwake_config_valid, wake_irq, dev_state
    );
endinterface : swk_mode_if

// ==== src/swk_mode_map.sv ====
`timescale 1ns/1ps
module swk_mode_map (
    input wire logic [2:0] cur_mode,
    input wire logic err,
    input wire logic to_stop,
    input wire logic to_sleep,
    input wire logic to_restart,
    output logic [2:0] new_mode,
    output logic new_swk,
    output logic new_err
);
    // =========================================
    // Field remap on stop or restart from normal, or on sleep from any state but sleep
    always_comb begin
        new_mode = cur_mode;
        new_swk = 1'b0;
        new_err = err;
        if (to_stop) begin
            if (cur_mode == swk_mode_pkg::MODE_NORMAL) begin
                new_mode = swk_mode_pkg::MODE_WAKE;
            end else if (cur_mode == swk_mode_pkg::MODE_NORMAL_SWK) begin
                new_mode = swk_mode_pkg::MODE_SWK;
            end
            new_swk = swk_mode_pkg::is_swk_mode(cur_mode) && !err;
        end else if (to_sleep || to_restart) begin
            if (cur_mode[2] == 1'b0
                && cur_mode != swk_mode_pkg::MODE_OFF0) begin
                new_mode = swk_mode_pkg::MODE_WAKE;
            end else if (swk_mode_pkg::is_swk_mode(cur_mode)) begin
                new_mode = swk_mode_pkg::MODE_SWK;
                if (to_restart) begin
                    new_err = 1'b1;
                end
            end
            new_swk = to_sleep && swk_mode_pkg::is_swk_mode(cur_mode) && !err;
        end
    end
endmodule : swk_mode_map

// ==== src/swk_mode_device.sv ====
`timescale 1ns/1ps
module swk_mode_device (
    input wire logic core_clk,
    input wire logic rst_n,
    swk_mode_if.device bus_if,
    input wire logic bus_rx_pin,
    input wire logic transmit_data_input,
    input wire logic wake_frame_in,
    input wire logic wake_pattern_in,
    input wire logic bus_idle_in,
    input wire logic err_overflow_in,
    output logic bus_tx_out,
    output logic receive_data_output,
    output logic [2:0] chan_op
);
    typedef struct packed {
        swk_mode_pkg::dev_state_t st;
        logic [2:0] mode;
        logic err;
        logic armed;
        logic swk_act;
        logic woken;
        logic sil;
        logic cfg;
        logic irq;
        logic [1:0] rx_sync;
        logic [1:0] wf_sync;
        logic [1:0] wp_sync;
        logic [1:0] idle_sync;
        logic [1:0] ovf_sync;
        logic tx;
        logic rxo;
        logic [2:0] op;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [2:0] map_mode;
    logic map_swk;
    logic map_err;
    logic go_stop;
    logic go_sleep;
    logic go_restart;
    logic wake_ev;
    logic wr_swk;

    // =========================================
    // Command decode, one channel per instance
    assign go_stop = bus_if.cmd_valid && s_q.st == swk_mode_pkg::DEV_NORMAL
        && bus_if.cmd_code == swk_mode_pkg::CMD_STOP;
    assign go_sleep = bus_if.cmd_valid && s_q.st != swk_mode_pkg::DEV_SLEEP
        && bus_if.cmd_code == swk_mode_pkg::CMD_SLEEP;
    assign go_restart = bus_if.cmd_valid && s_q.st == swk_mode_pkg::DEV_NORMAL
        && bus_if.cmd_code == swk_mode_pkg::CMD_RESTART;
    assign wake_ev = s_q.wf_sync[1] && s_q.swk_act && s_q.armed && !s_q.err;
    assign wr_swk = swk_mode_pkg::is_swk_mode(bus_if.cmd_mode);

    swk_mode_map u_map (
        .cur_mode(s_q.mode),
        .err(s_q.err),
        .to_stop(go_stop),
        .to_sleep(go_sleep),
        .to_restart(go_restart),
        .new_mode(map_mode),
        .new_swk(map_swk),
        .new_err(map_err)
    );

    // =========================================
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.rx_sync = {s_q.rx_sync[0], bus_rx_pin};
        s_d.wf_sync = {s_q.wf_sync[0], wake_frame_in};
        s_d.wp_sync = {s_q.wp_sync[0], wake_pattern_in};
        s_d.idle_sync = {s_q.idle_sync[0], bus_idle_in};
        s_d.ovf_sync = {s_q.ovf_sync[0], err_overflow_in};
        s_d.irq = 1'b0;
        if (bus_if.cfg_valid_set) begin
            s_d.cfg = 1'b1;
        end
        if (bus_if.cmd_valid) begin
            unique case (bus_if.cmd_code)
                swk_mode_pkg::CMD_WRITE_MODE: begin
                    if (s_q.st == swk_mode_pkg::DEV_NORMAL) begin
                        s_d.mode = bus_if.cmd_mode;
                        if (bus_if.cmd_mode != s_q.mode) begin
                            s_d.armed = 1'b1;
                            s_d.woken = 1'b0;
                        end
                        // A pending error keeps selective wake off
                        s_d.swk_act = wr_swk && s_d.cfg && !s_q.err;
                        if (wr_swk && !s_d.cfg) begin
                            s_d.err = 1'b1;
                        end
                    end
                end
                swk_mode_pkg::CMD_CLR_ERR: begin
                    if (!(s_q.mode[2] && !s_q.cfg)) begin
                        s_d.err = 1'b0;
                    end
                end
                swk_mode_pkg::CMD_STOP: begin
                    if (go_stop) begin
                        s_d.st = swk_mode_pkg::DEV_STOP;
                        s_d.mode = map_mode;
                        s_d.swk_act = map_swk;
                    end
                end
                swk_mode_pkg::CMD_SLEEP: begin
                    if (go_sleep) begin
                        s_d.st = swk_mode_pkg::DEV_SLEEP;
                        s_d.mode = map_mode;
                        s_d.swk_act = map_swk;
                        s_d.armed = 1'b1;
                        s_d.woken = 1'b0;
                    end
                end
                swk_mode_pkg::CMD_RESTART: begin
                    if (go_restart) begin
                        s_d.st = swk_mode_pkg::DEV_RESTART;
                        s_d.mode = map_mode;
                        s_d.err = map_err;
                        s_d.swk_act = 1'b0;
                        s_d.cfg = 1'b0;
                    end
                end
                swk_mode_pkg::CMD_FAILSAFE: begin
                    s_d.st = swk_mode_pkg::DEV_FAILSAFE;
                    s_d.mode = swk_mode_pkg::MODE_WAKE;
                    s_d.swk_act = 1'b0;
                end
                swk_mode_pkg::CMD_NORMAL: begin
                    if (s_q.st != swk_mode_pkg::DEV_SLEEP) begin
                        s_d.st = swk_mode_pkg::DEV_NORMAL;
                    end
                end
                default: begin
                end
            endcase
        end
        // Silence flag while monitoring, cleared by a wake pattern
        if (s_q.swk_act && s_q.idle_sync[1]) begin
            s_d.sil = 1'b1;
        end else if (s_q.wp_sync[1]) begin
            s_d.sil = 1'b0;
        end
        // Counter overflow: wake and set error, set wins over clear
        if (s_q.swk_act && s_q.ovf_sync[1]) begin
            s_d.err = 1'b1;
            s_d.swk_act = 1'b0;
            s_d.woken = 1'b1;
            s_d.armed = 1'b0;
        end
        // Valid wake frame
        if (wake_ev) begin
            s_d.woken = 1'b1;
            s_d.armed = 1'b0;
            if (s_q.st == swk_mode_pkg::DEV_SLEEP) begin
                s_d.st = swk_mode_pkg::DEV_RESTART;
                s_d.cfg = 1'b0;
                // Error stays clear unless an overflow sets it now
                s_d.mode = swk_mode_pkg::MODE_SWK;
                s_d.swk_act = 1'b0;
            end else begin
                s_d.irq = 1'b1;
            end
        end
        // Channel operation and data path
        unique case (s_d.mode[1:0])
            2'h0: s_d.op = swk_mode_pkg::OP_OFF;
            2'h1: s_d.op = swk_mode_pkg::OP_WAKE;
            2'h2: s_d.op = swk_mode_pkg::OP_RXONLY;
            2'h3: s_d.op = swk_mode_pkg::OP_NORMAL;
        endcase
        if (s_d.st == swk_mode_pkg::DEV_SLEEP
            && s_d.op != swk_mode_pkg::OP_OFF) begin
            s_d.op = swk_mode_pkg::OP_WAKE;
        end
        s_d.tx = (s_d.op == swk_mode_pkg::OP_NORMAL) ? transmit_data_input
            : 1'b1;
        s_d.rxo = (s_d.op == swk_mode_pkg::OP_NORMAL
            || s_d.op == swk_mode_pkg::OP_RXONLY) ? s_q.rx_sync[1] : 1'b1;
    end

    // =========================================
    // State register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.st <= swk_mode_pkg::DEV_NORMAL;
            s_q.mode <= swk_mode_pkg::MODE_RESET;
            s_q.err <= swk_mode_pkg::ERR_RESET;
            s_q.cfg <= swk_mode_pkg::CFG_RESET;
            s_q.rx_sync <= 2'h3;
            s_q.tx <= 1'b1;
            s_q.rxo <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // =========================================
    // Outputs from flip-flops, except the armed flag, which ANDs armed and swk_act
    assign bus_if.mode_readback = s_q.mode;
    assign bus_if.selwake_error_flag = s_q.err;
    assign bus_if.selwake_armed_flag = s_q.armed && s_q.swk_act;
    assign bus_if.bus_silence_flag = s_q.sil;
    assign bus_if.selwake_config_valid = s_q.cfg;
    assign bus_if.wake_irq = s_q.irq;
    assign bus_if.dev_state = s_q.st;
    assign bus_tx_out = s_q.tx;
    assign receive_data_output = s_q.rxo;
    assign chan_op = s_q.op;
endmodule : swk_mode_device

// ==== src/swk_mode_host.sv ====
`timescale 1ns/1ps
module swk_mode_host (
    input wire logic core_clk,
    input wire logic rst_n,
    swk_mode_if.host bus_if,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata
);
    typedef struct packed {
        logic cmd_valid;
        logic [2:0] cmd_code;
        logic [2:0] cmd_mode;
        logic cfg_set;
        logic [31:0] rdata;
    } state_t;

    state_t s_q;
    state_t s_d;

    // =========================================
    // Command register issues one pulse per write
    always_comb begin
        s_d = s_q;
        s_d.cmd_valid = 1'b0;
        s_d.cfg_set = 1'b0;
        s_d.rdata = 32'h0;
        if (wr_stb && addr == swk_mode_pkg::REG_CMD) begin
            s_d.cmd_valid = 1'b1;
            s_d.cmd_code = wdata[2:0];
            s_d.cmd_mode = wdata[6:4];
            s_d.cfg_set = wdata[8];
        end
        if (rd_stb && addr == swk_mode_pkg::REG_STAT) begin
            s_d.rdata = {19'h0, bus_if.dev_state, 1'b0,
                bus_if.wake_irq, bus_if.selwake_config_valid,
                bus_if.bus_silence_flag, bus_if.selwake_armed_flag,
                bus_if.selwake_error_flag, 1'b0, bus_if.mode_readback};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus_if.cmd_valid = s_q.cmd_valid;
    assign bus_if.cmd_code = s_q.cmd_code;
    assign bus_if.cmd_mode = s_q.cmd_mode;
    assign bus_if.cfg_valid_set = s_q.cfg_set;
    assign rdata = s_q.rdata;
endmodule : swk_mode_host

// ==== bench/swk_mode_properties.sv ====
`timescale 1ns/1ps
module swk_mode_properties (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_code,
    input wire logic [2:0] cmd_mode,
    input wire logic [2:0] mode_readback,
    input wire logic selwake_error_flag,
    input wire logic selwake_armed_flag,
    input wire logic [2:0] dev_state
);
    // ==========================================================
    // Decode of commands taken in the normal state
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic in_norm;
    logic stop_c;
    logic sleep_c;
    logic rest_c;
    logic [2:0] m;
    assign in_norm = cmd_valid && dev_state == swk_mode_pkg::DEV_NORMAL;
    assign stop_c = in_norm && cmd_code == swk_mode_pkg::CMD_STOP;
    assign sleep_c = in_norm && cmd_code == swk_mode_pkg::CMD_SLEEP;
    assign rest_c = in_norm && cmd_code == swk_mode_pkg::CMD_RESTART;
    assign m = mode_readback;

    // ==========================================================
    // Mode field mapping and armed flag checks
    chk_write_normal: assert property (
        in_norm && cmd_code == swk_mode_pkg::CMD_WRITE_MODE
        |=> m == $past(cmd_mode)) else $error("mode write lost");
    chk_write_locked: assert property (
        cmd_valid && cmd_code == swk_mode_pkg::CMD_WRITE_MODE
        && (dev_state == swk_mode_pkg::DEV_STOP
        || dev_state == swk_mode_pkg::DEV_SLEEP)
        |=> $stable(m)) else $error("mode changed in low power");
    chk_stop_normal: assert property (
        stop_c && m == 3'h3 |=> m == 3'h1) else $error("stop map 011");
    chk_stop_keep: assert property (
        stop_c && m != 3'h3 && m != 3'h7 |=> $stable(m))
        else $error("stop kept mode changed");
    chk_stop_swk: assert property (
        stop_c && m == 3'h7 |=> m == 3'h5) else $error("stop map 111");
    chk_sleep_wake: assert property (
        sleep_c && !m[2] && m != 3'h0 |=> m == 3'h1)
        else $error("sleep map to wake");
    chk_sleep_swk: assert property (
        sleep_c && m[2] && m[1:0] != 2'h0 |=> m == 3'h5)
        else $error("sleep map to selwake");
    chk_restart_map: assert property (
        rest_c && m[2] && m[1:0] != 2'h0
        |=> m == 3'h5 && selwake_error_flag) else $error("restart map");
    chk_off_keep: assert property (
        (stop_c || sleep_c || rest_c) && m[1:0] == 2'h0 |=> $stable(m))
        else $error("off mode changed");
    chk_err_disarm: assert property (
        selwake_error_flag |-> !selwake_armed_flag)
        else $error("armed while error set");
    chk_failsafe_off: assert property (
        in_norm && cmd_code == swk_mode_pkg::CMD_FAILSAFE
        |=> !selwake_armed_flag [*2]) else $error("armed in fail-safe");
endmodule : swk_mode_properties

// ==== bench/can_selective_wake_mode_control_tb_top.sv ====
`timescale 1ns/1ps
module can_selective_wake_mode_control_tb_top;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic rx_pin = 1'b1;
    logic tx_in = 1'b1;
    logic wake_frame = 1'b0;
    logic wake_pattern = 1'b0;
    logic idle = 1'b0;
    logic ovf = 1'b0;
    logic [31:0] rdata;
    logic bus_tx_out;
    logic receive_data_output;
    logic [2:0] chan_op;
    logic [31:0] st;
    int fails = 0;
    int check_count = 0;

    // ==========================================================
    // Both ends joined by the link
    swk_mode_if link_if ();
    swk_mode_host swk_mode_host_i (.core_clk(core_clk), .rst_n(rst_n),
        .bus_if(link_if), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata));
    swk_mode_device swk_mode_device_i (.core_clk(core_clk), .rst_n(rst_n),
        .bus_if(link_if), .bus_rx_pin(rx_pin), .transmit_data_input(tx_in),
        .wake_frame_in(wake_frame), .wake_pattern_in(wake_pattern),
        .bus_idle_in(idle),
        .err_overflow_in(ovf), .bus_tx_out(bus_tx_out),
        .receive_data_output(receive_data_output), .chan_op(chan_op));
    swk_mode_properties swk_mode_properties_i (.core_clk(core_clk),
        .rst_n(rst_n), .cmd_valid(link_if.cmd_valid),
        .cmd_code(link_if.cmd_code), .cmd_mode(link_if.cmd_mode),
        .mode_readback(link_if.mode_readback),
        .selwake_error_flag(link_if.selwake_error_flag),
        .selwake_armed_flag(link_if.selwake_armed_flag),
        .dev_state(link_if.dev_state));

    // Clock generation
    always #25 core_clk = ~core_clk;

    // ==========================================================
    // Bus tasks and comparison
    task automatic cmp(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : cmp

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        @(negedge core_clk);
        st = rdata;
    endtask : rd

    task automatic cmd(input logic [2:0] c, input logic [2:0] m,
                       input logic v);
        wr(swk_mode_pkg::REG_CMD, {23'h0, v, 1'b0, m, 1'b0, c});
    endtask : cmd

    task automatic wm(input logic [2:0] m);
        cmd(swk_mode_pkg::CMD_WRITE_MODE, m, 1'b0);
    endtask : wm

    task automatic expect_st(input logic [2:0] m, input logic e,
                             input logic [2:0] s);
        rd(swk_mode_pkg::REG_STAT);
        cmp("mode", {29'h0, m}, {29'h0, st[2:0]});
        cmp("err", {31'h0, e}, {31'h0, st[4]});
        cmp("state", {29'h0, s}, {29'h0, st[12:10]});
    endtask : expect_st

    task automatic do_reset;
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
    endtask : do_reset

    task automatic wake_pulse;
        @(posedge core_clk);
        wake_frame <= 1'b1;
        repeat (5) @(posedge core_clk);
        wake_frame <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask : wake_pulse

    // Expected field after leaving the normal state
    function automatic logic [2:0] low_map(input logic [2:0] c,
                                           input logic [2:0] m);
        if (c == swk_mode_pkg::CMD_STOP) begin
            return (m == 3'h3) ? 3'h1 : (m == 3'h7) ? 3'h5 : m;
        end
        return (m[1:0] == 2'h0) ? m : {m[2], 2'h1};
    endfunction : low_map

    function automatic logic has_selwake(input logic [2:0] m);
        return m[2] && m[1:0] != 2'h0;
    endfunction : has_selwake

    // ==========================================================
    // Scenarios
    task automatic t_map(input logic [2:0] c, input logic [2:0] s);
        logic [2:0] m;
        logic e;
        for (int k = 0; k < 16; k++) begin
            m = k[2:0];
            e = has_selwake(m) && (!k[3] || c == swk_mode_pkg::CMD_RESTART);
            do_reset;
            cmd(swk_mode_pkg::CMD_NONE, 3'h0, k[3]);
            wm(m);
            cmd(c, 3'h0, 1'b0);
            wm(3'h3);
            expect_st(low_map(c, m), e, s);
            if (c == swk_mode_pkg::CMD_SLEEP && k == 13) begin
                wake_pulse;
                expect_st(3'h5, 1'b0, swk_mode_pkg::DEV_RESTART);
                cmp("cfg", 32'h0, {31'h0, st[7]});
                // Re-entry into sleep with selective wake
                cmd(swk_mode_pkg::CMD_NORMAL, 3'h0, 1'b0);
                wm(3'h3);
                cmd(swk_mode_pkg::CMD_NONE, 3'h0, 1'b1);
                cmd(swk_mode_pkg::CMD_CLR_ERR, 3'h0, 1'b0);
                wm(3'h5);
                cmd(swk_mode_pkg::CMD_SLEEP, 3'h0, 1'b0);
                expect_st(3'h5, 1'b0, swk_mode_pkg::DEV_SLEEP);
                cmp("armed", 32'h1, {31'h0, st[5]});
            end
        end
    endtask : t_map

    task automatic t_normal;
        logic [2:0] m;
        logic seen;
        do_reset;
        cmd(swk_mode_pkg::CMD_NONE, 3'h0, 1'b1);
        tx_in <= 1'b0;
        rx_pin <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            m = i[2:0];
            wm(m);
            cmp("op", {30'h0, m[1:0]}, {29'h0, chan_op});
            cmp("tx", {31'h0, m[1:0] != 2'h3}, {31'h0, bus_tx_out});
            cmp("rxd", {31'h0, !m[1]}, {31'h0, receive_data_output});
        end
        rx_pin <= 1'b1;
        idle <= 1'b1;
        repeat (6) @(posedge core_clk);
        cmp("sil", 32'h1, {31'h0, link_if.bus_silence_flag});
        idle <= 1'b0;
        wake_pattern <= 1'b1;
        repeat (4) @(posedge core_clk);
        cmp("sil", 32'h0, {31'h0, link_if.bus_silence_flag});
        wake_pattern <= 1'b0;
        seen = 1'b0;
        wake_frame <= 1'b1;
        repeat (8) begin
            @(negedge core_clk);
            seen = seen | (link_if.wake_irq === 1'b1);
        end
        @(posedge core_clk);
        wake_frame <= 1'b0;
        cmp("irq", 32'h1, {31'h0, seen});
        cmp("rxd", 32'h1, {31'h0, receive_data_output});
        rd(swk_mode_pkg::REG_STAT);
        cmp("armed", 32'h0, {31'h0, st[5]});
        wm(3'h3);
        wm(3'h7);
        rd(swk_mode_pkg::REG_STAT);
        cmp("armed", 32'h1, {31'h0, st[5]});
        @(posedge core_clk);
        ovf <= 1'b1;
        repeat (5) @(posedge core_clk);
        ovf <= 1'b0;
        wr(4'h9, 32'h1);
        expect_st(3'h7, 1'b1, swk_mode_pkg::DEV_NORMAL);
        rd(4'hf);
        cmp("unmapped", 32'h0, st);
        cmd(swk_mode_pkg::CMD_FAILSAFE, 3'h0, 1'b0);
        rd(swk_mode_pkg::REG_STAT);
        cmp("state", 32'h4, {29'h0, st[12:10]});
    endtask : t_normal

    // ==========================================================
    // Verdict, main sequence and watchdog
    task automatic give_verdict;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        do_reset;
        expect_st(3'h0, 1'b0, swk_mode_pkg::DEV_NORMAL);
        t_map(swk_mode_pkg::CMD_STOP, swk_mode_pkg::DEV_STOP);
        t_map(swk_mode_pkg::CMD_SLEEP, swk_mode_pkg::DEV_SLEEP);
        t_map(swk_mode_pkg::CMD_RESTART, swk_mode_pkg::DEV_RESTART);
        t_normal;
        give_verdict;
    end

    initial begin
        #(50 * 20000);
        fails++;
        give_verdict;
    end
endmodule : can_selective_wake_mode_control_tb_top
